/* rtl/suc_pkg.sv */
// Purpose: constants, types and register map for the signed up/down counter
// Assumes: one clock, synchronous active-low reset, AXI4-Lite register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package suc_pkg;
   // register byte offsets
   localparam logic [7:0] SUC_CTRL_OFF = 8'h00;
   localparam logic [7:0] SUC_SET_LO_OFF = 8'h04;
   localparam logic [7:0] SUC_SET_HI_OFF = 8'h08;
   localparam logic [7:0] SUC_CONST_OFF = 8'h0c;
   localparam logic [7:0] SUC_COUNT_OFF = 8'h10;
   localparam logic [7:0] SUC_STAT_OFF = 8'h14;
   localparam logic [7:0] SUC_IRQ_OFF = 8'h18;
   localparam logic [7:0] SUC_MASK_OFF = 8'h1c;
   // control field positions
   localparam int SUC_CTRL_SRC_BIT = 0;
   localparam int SUC_CTRL_LATCH_BIT = 1;
   localparam int SUC_CTRL_CLEAR_BIT = 2;
   // status field positions
   localparam int SUC_STAT_CONTACT_BIT = 0;
   localparam int SUC_STAT_DIR_BIT = 1;
   // interrupt event positions
   localparam int SUC_IRQ_MATCH_BIT = 0;
   localparam int SUC_IRQ_WRAP_BIT = 1;
   localparam int SUC_IRQ_CLEAR_BIT = 2;
   localparam int SUC_IRQ_W = 3;
   // reset values
   localparam logic [31:0] SUC_COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] SUC_CONST_RST = 32'h0000_0000;
   localparam logic [15:0] SUC_HALF_RST = 16'h0000;
   localparam logic [2:0] SUC_MASK_RST = 3'h0;
   // axi response codes
   localparam logic [1:0] SUC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SUC_RESP_SLVERR = 2'h2;

   // scan-side inputs of one counter, already synchronised
   typedef struct packed {
      logic count_pulse_input;
      logic clear_trigger_input;
      logic direction_drive_input;
   } suc_scan_s;

   // software-held configuration
   typedef struct packed {
      logic use_registers;
      logic latching;
      logic [31:0] setting_const;
      logic [15:0] set_lo;
      logic [15:0] set_hi;
      logic [SUC_IRQ_W-1:0] mask;
   } suc_cfg_s;
endpackage : suc_pkg

/* rtl/suc_core.sv */
// Purpose: one signed 32-bit up/down event counter with compare contact
// Assumes: inputs synchronous to aclk, one-cycle clear and edge strobes
// Notes: latching mode keeps count and contact through a warm reset
`timescale 1ns/100ps
module suc_core
   import suc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic latching,
   input wire logic count_edge,
   input wire logic count_down,
   input wire logic clear_cmd,
   input wire logic [31:0] setting,
   output logic [31:0] present_count,
   output logic contact,
   output logic match_evt,
   output logic wrap_evt
);
   // all state of the counter
   typedef struct packed {
      logic [31:0] count;
      logic contact;
      logic pending;
      logic match;
      logic wrap;
   } suc_core_s;

   suc_core_s r;
   suc_core_s next_r;

   // signed equality on the stored count
   function automatic logic suc_eq(input logic [31:0] a, input logic [31:0] b);
      suc_eq = ($signed(a) == $signed(b));
   endfunction : suc_eq

   // counting evaluation, then contact in the following cycle
   always_comb begin
      next_r = r;
      next_r.match = 1'b0;
      next_r.wrap = 1'b0;
      next_r.pending = 1'b0;
      if (clear_cmd) begin
         next_r.count = SUC_COUNT_RST;
         next_r.contact = 1'b0;
      end else begin
         if (count_edge) begin
            // step by exactly one; picks the sign; wraps naturally
            next_r.count = count_down ? r.count - 32'h0000_0001 : r.count + 32'h0000_0001;
            next_r.wrap = count_down ? (r.count == 32'h8000_0000) : (r.count == 32'h7fff_ffff);
            next_r.pending = 1'b1;
         end
         // contact acts once the step has settled
         if (r.pending && suc_eq(r.count, setting)) begin
            // up sets, down clears; count never held
            next_r.contact = ~count_down;
            next_r.match = 1'b1;
         end
      end
   end

   // register the state; latching survives reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r.pending <= 1'b0;
         r.match <= 1'b0;
         r.wrap <= 1'b0;
         // an unknown latch input falls to the clearing branch
         if (latching) begin
            // count and contact kept as they are
         end else begin
            r.count <= SUC_COUNT_RST;
            r.contact <= 1'b0;
         end
      end else begin
         r <= next_r;
      end
   end

   assign present_count = r.count;
   assign contact = r.contact;
   assign match_evt = r.match;
   assign wrap_evt = r.wrap;
endmodule : suc_core

/* rtl/suc_top.sv */
// Purpose: counter with scan pins and an AXI4-Lite register file
// Assumes: scan pins are asynchronous, registers reached over AXI4-Lite
// Notes: one write and one read in flight; unmapped addresses answer slverr
//        scan pins pass two flip-flops and an edge detector, so a step lands
//        three edges after its pin rises
//        the latch mode bit is kept through reset; an unknown power-up value
//        settles to off at the first reset edge
`timescale 1ns/100ps
module suc_top
   import suc_pkg::*;
(
   // clock and synchronous active-low reset
   input wire logic aclk,
   input wire logic aresetn,
   // scan-side pins, asynchronous to aclk
   input wire logic count_pulse_input,
   input wire logic clear_trigger_input,
   input wire logic direction_drive_input,
   // compare contact and level interrupt
   output logic contact,
   output logic irq,
   // write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // all state of the top
   typedef struct packed {
      // pin synchronisers and edge detectors
      suc_scan_s sync1;       // first synchroniser stage, read only by sync2
      suc_scan_s sync2;       // second stage, safe to use
      logic pulse_prev;       // last count level seen
      logic clear_prev;       // last clear level seen
      // software configuration; the latch bit survives reset
      suc_cfg_s cfg;
      logic sw_clear;         // one-cycle clear from software
      // sticky event flags, cleared by writing ones
      logic [SUC_IRQ_W-1:0] stat;
      // write address and data, held until both are in
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      // write response, held until bready
      logic bvalid;
      logic [1:0] bresp;
      // read answer, held until rready
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } suc_top_s;

   suc_top_s r;
   suc_top_s next_r;

   // strobes and setting into the counter
   logic count_edge;
   logic clear_cmd;
   logic [31:0] setting;
   // results from the counter
   logic [31:0] present_count;
   logic match_evt;
   logic wrap_evt;

   // byte-lane merge for a register write
   // lanes without a strobe keep their old byte, so a partial write
   // to one half of the setting leaves the rest alone
   function automatic logic [31:0] suc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      suc_merge = res;
   endfunction : suc_merge

   // rising edge of the synchronised count input
   // edge detect reads only the second stage, never a metastable first stage
   assign count_edge = r.sync2.count_pulse_input & ~r.pulse_prev;
   // clear on rising clear input or software strobe
   // a held clear level clears once; software clear is a one-cycle strobe
   assign clear_cmd = (r.sync2.clear_trigger_input & ~r.clear_prev) | r.sw_clear;
   // constant or register pair; lower register is low half
   // the pair is glued without a shadow, so a change of both halves
   // should be made while no steps arrive
   assign setting = r.cfg.use_registers ? {r.cfg.set_hi, r.cfg.set_lo} : r.cfg.setting_const;

   // counter proper
   // it sees clean one-cycle strobes and a settled direction only
   suc_core u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .latching(r.cfg.latching),
      .count_edge(count_edge),
      .count_down(r.sync2.direction_drive_input),
      .clear_cmd(clear_cmd),
      .setting(setting),
      .present_count(present_count),
      .contact(contact),
      .match_evt(match_evt),
      .wrap_evt(wrap_evt)
   );

   // next state: synchronisers, events, bus slave
   always_comb begin
      logic wr_go;
      logic ok;
      logic [SUC_IRQ_W-1:0] w1c;
      logic [31:0] merged;
      wr_go = 1'b0;
      ok = 1'b0;
      w1c = '0;
      merged = 32'h0000_0000;
      next_r = r;
      // first stage samples the pins, second stage reads only the first
      next_r.sync1.count_pulse_input = count_pulse_input;
      next_r.sync1.clear_trigger_input = clear_trigger_input;
      next_r.sync1.direction_drive_input = direction_drive_input;
      next_r.sync2 = r.sync1;
      // previous levels rest low after reset, like the idle pins,
      // so no false edge follows a reset
      next_r.pulse_prev = r.sync2.count_pulse_input;
      next_r.clear_prev = r.sync2.clear_trigger_input;
      // software clear lasts one cycle
      next_r.sw_clear = 1'b0;
      // capture write address and data in either order
      if (s_axi_awvalid && !r.aw_got) begin
         // address taken; awready drops until the write is done
         next_r.aw_got = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got) begin
         // data taken; wready drops until the write is done
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      // perform the write once both halves are held and b is free
      // a stalled bready stalls the next write, so no response queue is needed
      if (r.aw_got && r.w_got && !r.bvalid) begin
         wr_go = 1'b1;
         ok = 1'b1;
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         case (r.awaddr)
            // source select, latch mode, clear strobe
            SUC_CTRL_OFF: begin
               if (r.wstrb[0]) begin
                  next_r.cfg.use_registers = r.wdata[SUC_CTRL_SRC_BIT];
                  next_r.cfg.latching = r.wdata[SUC_CTRL_LATCH_BIT];
                  next_r.sw_clear = r.wdata[SUC_CTRL_CLEAR_BIT];
               end
            end
            SUC_SET_LO_OFF: begin
               merged = suc_merge({16'h0000, r.cfg.set_lo}, r.wdata, r.wstrb);
               next_r.cfg.set_lo = merged[15:0];
            end
            SUC_SET_HI_OFF: begin
               merged = suc_merge({16'h0000, r.cfg.set_hi}, r.wdata, r.wstrb);
               next_r.cfg.set_hi = merged[15:0];
            end
            // constant setting
            SUC_CONST_OFF: next_r.cfg.setting_const = suc_merge(r.cfg.setting_const, r.wdata, r.wstrb);
            // read-only words accept the write and ignore it
            SUC_COUNT_OFF: ;
            SUC_STAT_OFF: ;
            // write ones to clear event flags
            SUC_IRQ_OFF: w1c = r.wstrb[0] ? r.wdata[SUC_IRQ_W-1:0] : '0;
            // interrupt mask
            SUC_MASK_OFF: begin
               if (r.wstrb[0]) begin
                  next_r.cfg.mask = r.wdata[SUC_IRQ_W-1:0];
               end
            end
            // nothing mapped here
            default: ok = 1'b0;
         endcase
         next_r.bresp = ok ? SUC_RESP_OKAY : SUC_RESP_SLVERR;
      end
      // response retires when the master takes it
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      // sticky events: set beats a write-one clear,
      // so an event in the clearing cycle is never lost
      next_r.stat = (r.stat & ~w1c) | {clear_cmd, wrap_evt, match_evt};
      // reads answer one cycle after the address is taken
      if (s_axi_arvalid && !r.rvalid) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = SUC_RESP_OKAY;
         case (s_axi_araddr)
            SUC_CTRL_OFF: next_r.rdata = {29'h0, 1'b0, r.cfg.latching, r.cfg.use_registers};
            SUC_SET_LO_OFF: next_r.rdata = {16'h0000, r.cfg.set_lo};
            SUC_SET_HI_OFF: next_r.rdata = {16'h0000, r.cfg.set_hi};
            SUC_CONST_OFF: next_r.rdata = r.cfg.setting_const;
            // count straight from the core register
            SUC_COUNT_OFF: next_r.rdata = present_count;
            // live contact and synchronised direction
            SUC_STAT_OFF: next_r.rdata = {30'h0, r.sync2.direction_drive_input, contact};
            SUC_IRQ_OFF: next_r.rdata = {29'h0, r.stat};
            SUC_MASK_OFF: next_r.rdata = {29'h0, r.cfg.mask};
            // unmapped reads give zero with slverr
            default: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rresp = SUC_RESP_SLVERR;
            end
         endcase
      end else if (r.rvalid && s_axi_rready) begin
         // answer taken; the read address channel opens again
         next_r.rvalid = 1'b0;
      end
      // held write data need not change once the write is done
      if (wr_go) begin
         next_r.wdata = r.wdata;
      end
   end

   // register the state; latch mode survives a warm reset
   // reset is synchronous, so it acts only on a clock edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // synchronisers and edge detectors back to the idle low level
         r.sync1 <= '0;
         r.sync2 <= '0;
         r.pulse_prev <= 1'b0;
         r.clear_prev <= 1'b0;
         // configuration apart from the latch mode bit
         r.cfg.use_registers <= 1'b0;
         r.cfg.setting_const <= SUC_CONST_RST;
         r.cfg.set_lo <= SUC_HALF_RST;
         r.cfg.set_hi <= SUC_HALF_RST;
         r.cfg.mask <= SUC_MASK_RST;
         // latch mode kept; an unknown power-up value falls to off
         if (r.cfg.latching) begin
            r.cfg.latching <= 1'b1;
         end else begin
            r.cfg.latching <= 1'b0;
         end
         r.sw_clear <= 1'b0;
         r.stat <= '0;
         // bus slave idle, every channel ready
         r.aw_got <= 1'b0;
         r.awaddr <= 8'h00;
         r.w_got <= 1'b0;
         r.wdata <= 32'h0000_0000;
         r.wstrb <= 4'h0;
         r.bvalid <= 1'b0;
         r.bresp <= SUC_RESP_OKAY;
         r.rvalid <= 1'b0;
         r.rdata <= 32'h0000_0000;
         r.rresp <= SUC_RESP_OKAY;
      end else begin
         r <= next_r;
      end
   end

   // handshakes straight from the held flags
   assign s_axi_awready = ~r.aw_got;
   assign s_axi_wready = ~r.w_got;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = ~r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   // level interrupt while any unmasked event is pending
   assign irq = |(r.stat & r.cfg.mask);
endmodule : suc_top

/* test/suc_assertions.sv */
// Purpose: port-level checks of the signed up/down counter
// Assumes: scan pins move at least four cycles apart
// Notes: pin sync plus edge detect delays a step by three edges and the contact by four
`timescale 1ns/100ps
module suc_assertions
   import suc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic count_pulse_input,
   input wire logic clear_trigger_input,
   input wire logic direction_drive_input,
   input wire logic contact,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a count rise that has just passed the synchronisers
   sequence step_recent;
      $past(count_pulse_input, 3) || $past(count_pulse_input, 4) || $past(count_pulse_input, 5);
   endsequence
   // a clear rise that has just passed the synchronisers
   sequence clear_recent;
      $past(clear_trigger_input, 3) || $past(clear_trigger_input, 4);
   endsequence
   AST_ON_AFTER_STEP: assert property ($rose(contact) |-> step_recent)
      else $error("contact rose without a count step");
   AST_UP_ON: assert property ($rose(contact) |-> !$past(direction_drive_input, 5))
      else $error("contact rose while counting down");
   // a reset edge may also drop the contact, so it is excused
   AST_DOWN_OFF: assert property ($fell(contact) |-> ($past(direction_drive_input, 5) || !$past(aresetn))
      or clear_recent)
      else $error("contact fell while counting up");
   AST_CLEAR_OFF: assert property ($rose(clear_trigger_input) |-> ##[3:6] !contact)
      else $error("contact still on after clear");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
endmodule : suc_assertions

bind suc_top suc_assertions suc_assertions_inst (.aclk, .aresetn, .count_pulse_input,
   .clear_trigger_input, .direction_drive_input, .contact, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* test/suc_scan_model.sv */
// Purpose: program-scan model driving the counter's scan pins
// Assumes: pins change only just after a rising edge
// Notes: each level is held five cycles, above the four the pins need
`timescale 1ns/100ps
module suc_scan_model (
   output logic count_pulse_input,
   output logic clear_trigger_input,
   output logic direction_drive_input,
   input wire logic aclk
);
   // idle scan: every pin off
   initial begin
      count_pulse_input = 1'h0;
      clear_trigger_input = 1'h0;
      direction_drive_input = 1'h0;
   end
   // direction bit drive, held steady around steps
   task set_dir(input logic down);
      @(posedge aclk);
      direction_drive_input <= down;
      repeat (6) @(posedge aclk);
   endtask : set_dir
   // one rise per step; clear may rise on the same edge
   task act(input int n, input logic cnt, input logic clr);
      repeat (n) begin
         @(posedge aclk);
         count_pulse_input <= cnt;
         clear_trigger_input <= clr;
         repeat (5) @(posedge aclk);
         count_pulse_input <= 1'h0;
         clear_trigger_input <= 1'h0;
         repeat (5) @(posedge aclk);
      end
   endtask : act
endmodule : suc_scan_model

/* test/tb.sv */
// Purpose: self-checking bench of the counter top
// Assumes: scan model drives the pins, bench drives the register bus
// Notes: wrap past the extremes is not reachable in a short run
`timescale 1ns/100ps
module tb;
   import suc_pkg::*;
   // one row: direction, step count, expected count and contact
   typedef struct packed {logic down; logic [7:0] steps; logic [31:0] count; logic on;} suc_row_s;
   logic aclk, aresetn, count_pulse_input, clear_trigger_input, direction_drive_input, contact, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int errors, comparisons;
   // setting is minus five, so matches are reached both counting up and counting down
   suc_row_s rows [6] = '{'{1'h1, 8'h06, 32'hffff_fffa, 1'h0}, '{1'h0, 8'h01, 32'hffff_fffb, 1'h1},
      '{1'h0, 8'h02, 32'hffff_fffd, 1'h1}, '{1'h1, 8'h02, 32'hffff_fffb, 1'h0},
      '{1'h1, 8'h01, 32'hffff_fffa, 1'h0}, '{1'h0, 8'h01, 32'hffff_fffb, 1'h1}};
   suc_top suc_top_inst (.aclk, .aresetn, .count_pulse_input, .clear_trigger_input, .direction_drive_input,
      .contact, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   suc_scan_model suc_scan_model_inst (.aclk, .count_pulse_input, .clear_trigger_input,
      .direction_drive_input);
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // write: address and data offered together, response stalled a little
   task wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      // wait as long as the answer takes; only the watchdog ends a hang
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bready && s_axi_bvalid) break;
         s_axi_bready <= (n >= 2);
         n++;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task rdw(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rready && s_axi_rvalid) break;
         s_axi_rready <= (n >= 2);
         n++;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rdw
   task rst;
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
   endtask : rst
   task wrap_up;
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   // watchdog: the tests need well under ten thousand cycles
   initial begin
      repeat (30000) @(posedge aclk);
      errors++;
      wrap_up();
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      rst();
      rdw(SUC_COUNT_OFF);
      chk("count", SUC_COUNT_RST, rd);
      chk("irq", 32'h0, {31'h0, irq});
      wr(SUC_SET_LO_OFF, 32'h0000_fffb);
      wr(SUC_SET_HI_OFF, 32'h0000_ffff);
      wr(SUC_CTRL_OFF, 32'h0000_0001);
      foreach (rows[i]) begin
         suc_scan_model_inst.set_dir(rows[i].down);
         suc_scan_model_inst.act(rows[i].steps, 1'h1, 1'h0);
         rdw(SUC_COUNT_OFF);
         chk("count", rows[i].count, rd);
         chk("contact", {31'h0, rows[i].on}, {31'h0, contact});
      end
      chk("irq", 32'h0, {31'h0, irq});
      wr(SUC_MASK_OFF, 32'h0000_0001);
      chk("irq", 32'h1, {31'h0, irq});
      wr(SUC_IRQ_OFF, 32'h0000_0001);
      chk("irq", 32'h0, {31'h0, irq});
      suc_scan_model_inst.act(1, 1'h0, 1'h1);
      rdw(SUC_COUNT_OFF);
      chk("count", 32'h0, rd);
      chk("contact", 32'h0, {31'h0, contact});
      suc_scan_model_inst.act(2, 1'h1, 1'h0);
      suc_scan_model_inst.act(1, 1'h1, 1'h1);
      rdw(SUC_COUNT_OFF);
      chk("count", 32'h0, rd);
      rdw(8'h20);
      chk("rresp", {30'h0, SUC_RESP_SLVERR}, {30'h0, rs});
      chk("rdata", 32'h0, rd);
      wr(8'h24, 32'h0000_0001);
      chk("bresp", {30'h0, SUC_RESP_SLVERR}, {30'h0, rs});
      // latching counter with a constant setting survives a reset
      wr(SUC_CONST_OFF, 32'h0000_0003);
      wr(SUC_CTRL_OFF, 32'h0000_0002);
      suc_scan_model_inst.act(3, 1'h1, 1'h0);
      chk("contact", 32'h1, {31'h0, contact});
      rst();
      rdw(SUC_COUNT_OFF);
      chk("count", 32'h3, rd);
      chk("contact", 32'h1, {31'h0, contact});
      suc_scan_model_inst.act(1, 1'h1, 1'h0);
      rdw(SUC_COUNT_OFF);
      chk("count", 32'h4, rd);
      wr(SUC_CTRL_OFF, 32'h0000_0000);
      rst();
      rdw(SUC_COUNT_OFF);
      chk("count", 32'h0, rd);
      wrap_up();
   end
endmodule : tb
